/* File: hw/clk_gate_pkg.sv */
// Constants, register map and carrier types for the doze divider and module gating.
// Assumes one 50 MHz system clock and an APB master with 32-bit data.
package clk_gate_pkg;

    localparam int          ADDR_W       = 16;
    localparam int          DATA_W       = 32;
    localparam int          REG_W        = 16;
    localparam int          RATIO_W      = 3;
    localparam int          CNT_W        = 7;

    // Register indices; the byte address is four times the index
    localparam logic [15:0] IDX_CLOCK_DIVIDER_CONTROL   = 16'h0744;
    localparam logic [15:0] IDX_W1       = 16'h0760;
    localparam logic [15:0] IDX_W2       = 16'h0762;
    localparam logic [15:0] IDX_W3       = 16'h0764;
    localparam logic [15:0] IDX_W4       = 16'h0766;
    localparam logic [15:0] IDX_W6       = 16'h076A;
    localparam logic [15:0] IDX_W7       = 16'h076C;

    // Clock divider control field positions
    localparam int          ROI_BIT      = 15;
    localparam int          RATIO_HI     = 14;
    localparam int          RATIO_LO     = 12;
    localparam int          SLOW_BIT     = 11;

    // Implemented bits of each word; the rest read as zero
    localparam logic [15:0] MASK_CLOCK_DIVIDER_CONTROL  = 16'hF800;
    localparam logic [15:0] MASK_W1      = 16'hFFFF;
    localparam logic [15:0] MASK_W2      = 16'hFFFF;
    localparam logic [15:0] MASK_W3      = 16'hF7FF;
    localparam logic [15:0] MASK_W4      = 16'h002C;
    localparam logic [15:0] MASK_W6      = 16'h3F01;
    localparam logic [15:0] MASK_W7      = 16'h0018;
    localparam logic [15:0] RESET_WORD   = 16'h0000;
    localparam logic [2:0]  RATIO_1TO1   = 3'h0;

    typedef enum logic [2:0] {
        SEL_NONE, SEL_CLOCK_DIVIDER_CONTROL, SEL_W1, SEL_W2, SEL_W3, SEL_W4, SEL_W6, SEL_W7
    } sel_t;

    typedef struct packed {
        logic               recover_on_interrupt;
        logic [RATIO_W-1:0] doze_ratio;
        logic               slow_core_enable;
    } clock_divider_control_t;

    typedef struct packed {
        logic [REG_W-1:0] module_disable_word1;
        logic [REG_W-1:0] module_disable_word2;
        logic [REG_W-1:0] module_disable_word3;
        logic [REG_W-1:0] module_disable_word4;
        logic [REG_W-1:0] module_disable_word6;
        logic [REG_W-1:0] module_disable_word7;
    } module_off_t;

    typedef struct packed {
        logic [CNT_W-1:0]   cnt;
        logic [RATIO_W-1:0] ratio_act;
    } divider_state_t;

    typedef struct packed {
        clock_divider_control_t clock_divider_control;
        module_off_t            sw;
        module_off_t            live;
        logic [DATA_W-1:0]      rdata;
        logic                   rerr;
    } ctrl_state_t;

    function automatic logic [15:0] byte_addr(input logic [15:0] idx);
        return {idx[13:0], 2'b00};
    endfunction

    // Last count of a CPU cycle: ratio code r gives a period of 2**r system clocks
    function automatic logic [CNT_W-1:0] ratio_terminal(input logic [RATIO_W-1:0] r);
        return (7'h01 << r) - 7'h01;
    endfunction

endpackage

/* File: hw/doze_divider.sv */
// Doze divider: one-cycle CPU clock enable at a ratio of the system clock.
// Assumes the ratio and enable come from flip-flops in the same clock domain.
`timescale 1ns/1ns
module doze_divider (
    input  wire logic                               pclk,
    input  wire logic                               presetn,
    input  wire logic                               slow_core_enable,
    input  wire logic [clk_gate_pkg::RATIO_W-1:0]   doze_ratio,
    output logic                                    cpu_clk_en,
    output logic [clk_gate_pkg::RATIO_W-1:0]        ratio_act
);

    clk_gate_pkg::divider_state_t state_q;
    clk_gate_pkg::divider_state_t state_d;
    logic                         tick;

    always_comb begin
        state_d = state_q;
        tick    = (state_q.cnt == clk_gate_pkg::ratio_terminal(state_q.ratio_act));
        if (tick) begin
            // New ratio only at a CPU cycle boundary, so no short pulse reaches the core
            state_d.cnt       = '0;
            state_d.ratio_act = slow_core_enable ? doze_ratio
                                                 : clk_gate_pkg::RATIO_1TO1;
        end else begin
            state_d.cnt = state_q.cnt + 7'h01;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    // Enable derived from pclk, which also runs the peripherals at full rate, keeps both in lock step
    assign cpu_clk_en = tick;
    assign ratio_act  = state_q.ratio_act;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    full_rate_a: assert property (state_q.ratio_act == 3'h0 |-> cpu_clk_en)
        else $error("CPU enable missing at 1:1");
    period_end_a: assert property (cpu_clk_en |-> ##1 state_q.cnt == 7'h00)
        else $error("Divider did not restart after a CPU pulse");
    period_len_a: assert property (cpu_clk_en && slow_core_enable && doze_ratio == 3'h2
        |-> ##1 (!cpu_clk_en) [*3] ##1 cpu_clk_en)
        else $error("1:4 period is not four clocks");
    boundary_a: assert property ($changed(state_q.ratio_act) |-> $past(cpu_clk_en))
        else $error("Ratio changed inside a CPU cycle");

endmodule

/* File: hw/doze_gating_ctrl.sv */
// Doze control and per-peripheral clock disable words behind an APB slave.
// Assumes APB master and all gated modules run on pclk; peripherals use periph_clk_en.
`timescale 1ns/1ns
// Behaviour
// - System clock untouched in doze; peripherals stay at full rate, only CPU slows.
// - CPU enable derives from the same clock so both stay synchronized.
// - Doze happens only while the slow core enable bit 11 is set.
// - Ratio field bits 14:12 picks 1:1 to 1:128 in power-of-two steps.
// - Ratio field resets to 1:1.
// - With bit 15 set, an interrupt ends doze and restores full speed.
// - With bit 15 clear, interrupts leave doze and ratio alone.
// - Word1 gates timers five to one, encoder, PWM, codec, I2C, UARTs, SPI, CAN, ADC.
// - Word2 gates capture channels eight to one and compare channels eight to one.
// - Word3 gates timers nine to six and the further listed modules.
// - Word6 holds PWM generators six to one and third SPI; other bits read zero.
// - A set disable bit stops that module's clocks and register access.
// - A disable change takes effect after one instruction cycle.
module doze_gating_ctrl (
    input  wire logic                               pclk,
    input  wire logic                               presetn,
    input  wire logic                               psel,
    input  wire logic                               penable,
    input  wire logic                               pwrite,
    input  wire logic [clk_gate_pkg::ADDR_W-1:0]    paddr,
    input  wire logic [clk_gate_pkg::DATA_W-1:0]    pwdata,
    input  wire logic [3:0]                         pstrb,
    output logic [clk_gate_pkg::DATA_W-1:0]         prdata,
    output logic                                    pready,
    output logic                                    pslverr,
    input  wire logic                               irq_pending,
    output logic                                    cpu_clk_en,
    output logic                                    periph_clk_en,
    output logic                                    doze_active,
    output clk_gate_pkg::module_off_t               module_off,
    output clk_gate_pkg::module_off_t               module_clk_en
);

    clk_gate_pkg::ctrl_state_t  state_q;
    clk_gate_pkg::ctrl_state_t  state_d;
    clk_gate_pkg::sel_t         sel;
    logic                       setup_phase;
    logic                       wr_access;
    logic [clk_gate_pkg::RATIO_W-1:0] ratio_act;

    function automatic clk_gate_pkg::sel_t decode(input logic [15:0] a);
        unique case (a)
            clk_gate_pkg::byte_addr(clk_gate_pkg::IDX_CLOCK_DIVIDER_CONTROL): return clk_gate_pkg::SEL_CLOCK_DIVIDER_CONTROL;
            clk_gate_pkg::byte_addr(clk_gate_pkg::IDX_W1):     return clk_gate_pkg::SEL_W1;
            clk_gate_pkg::byte_addr(clk_gate_pkg::IDX_W2):     return clk_gate_pkg::SEL_W2;
            clk_gate_pkg::byte_addr(clk_gate_pkg::IDX_W3):     return clk_gate_pkg::SEL_W3;
            clk_gate_pkg::byte_addr(clk_gate_pkg::IDX_W4):     return clk_gate_pkg::SEL_W4;
            clk_gate_pkg::byte_addr(clk_gate_pkg::IDX_W6):     return clk_gate_pkg::SEL_W6;
            clk_gate_pkg::byte_addr(clk_gate_pkg::IDX_W7):     return clk_gate_pkg::SEL_W7;
            default:                                           return clk_gate_pkg::SEL_NONE;
        endcase
    endfunction

    // Byte lanes 0 and 1 only; the upper lanes have no storage
    function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] wd,
                                          input logic [3:0] strb, input logic [15:0] mask);
        logic [15:0] v;
        v = old;
        if (strb[0]) begin
            v[7:0] = wd[7:0];
        end
        if (strb[1]) begin
            v[15:8] = wd[15:8];
        end
        return v & mask;
    endfunction

    function automatic logic [15:0] pack_clock_divider_control(input clk_gate_pkg::clock_divider_control_t c);
        logic [15:0] v;
        v = clk_gate_pkg::RESET_WORD;
        v[clk_gate_pkg::ROI_BIT]                         = c.recover_on_interrupt;
        v[clk_gate_pkg::RATIO_HI:clk_gate_pkg::RATIO_LO] = c.doze_ratio;
        v[clk_gate_pkg::SLOW_BIT]                        = c.slow_core_enable;
        return v;
    endfunction

    assign sel         = decode(paddr);
    assign setup_phase = psel && !penable;
    assign wr_access   = psel && penable && pwrite && (sel != clk_gate_pkg::SEL_NONE);

    always_comb begin
        logic [15:0] rd;
        logic [15:0] cw;
        rd      = clk_gate_pkg::RESET_WORD;
        cw      = clk_gate_pkg::RESET_WORD;
        state_d = state_q;

        // Read data captured in the setup cycle so prdata comes from a flip-flop
        if (setup_phase) begin
            unique case (sel)
                clk_gate_pkg::SEL_CLOCK_DIVIDER_CONTROL: rd = pack_clock_divider_control(state_q.clock_divider_control);
                clk_gate_pkg::SEL_W1:     rd = state_q.sw.module_disable_word1;
                clk_gate_pkg::SEL_W2:     rd = state_q.sw.module_disable_word2;
                clk_gate_pkg::SEL_W3:     rd = state_q.sw.module_disable_word3;
                clk_gate_pkg::SEL_W4:     rd = state_q.sw.module_disable_word4;
                clk_gate_pkg::SEL_W6:     rd = state_q.sw.module_disable_word6;
                clk_gate_pkg::SEL_W7:     rd = state_q.sw.module_disable_word7;
                clk_gate_pkg::SEL_NONE:   rd = clk_gate_pkg::RESET_WORD;
            endcase
            state_d.rdata = {16'h0000, rd};
            state_d.rerr  = (sel == clk_gate_pkg::SEL_NONE);
        end

        if (wr_access) begin
            unique case (sel)
                clk_gate_pkg::SEL_CLOCK_DIVIDER_CONTROL: begin
                    cw = merge(pack_clock_divider_control(state_q.clock_divider_control), pwdata, pstrb,
                               clk_gate_pkg::MASK_CLOCK_DIVIDER_CONTROL);
                    state_d.clock_divider_control.recover_on_interrupt =
                        cw[clk_gate_pkg::ROI_BIT];
                    state_d.clock_divider_control.doze_ratio =
                        cw[clk_gate_pkg::RATIO_HI:clk_gate_pkg::RATIO_LO];
                    state_d.clock_divider_control.slow_core_enable =
                        cw[clk_gate_pkg::SLOW_BIT];
                end
                clk_gate_pkg::SEL_W1: state_d.sw.module_disable_word1 =
                    merge(state_q.sw.module_disable_word1, pwdata, pstrb,
                          clk_gate_pkg::MASK_W1);
                clk_gate_pkg::SEL_W2: state_d.sw.module_disable_word2 =
                    merge(state_q.sw.module_disable_word2, pwdata, pstrb,
                          clk_gate_pkg::MASK_W2);
                clk_gate_pkg::SEL_W3: state_d.sw.module_disable_word3 =
                    merge(state_q.sw.module_disable_word3, pwdata, pstrb,
                          clk_gate_pkg::MASK_W3);
                clk_gate_pkg::SEL_W4: state_d.sw.module_disable_word4 =
                    merge(state_q.sw.module_disable_word4, pwdata, pstrb,
                          clk_gate_pkg::MASK_W4);
                clk_gate_pkg::SEL_W6: state_d.sw.module_disable_word6 =
                    merge(state_q.sw.module_disable_word6, pwdata, pstrb,
                          clk_gate_pkg::MASK_W6);
                clk_gate_pkg::SEL_W7: state_d.sw.module_disable_word7 =
                    merge(state_q.sw.module_disable_word7, pwdata, pstrb,
                          clk_gate_pkg::MASK_W7);
                clk_gate_pkg::SEL_NONE: begin
                end
            endcase
        end

        // Recovery beats a same-cycle write; full speed returns at the end of the CPU cycle in progress
        if (irq_pending && state_q.clock_divider_control.recover_on_interrupt) begin
            state_d.clock_divider_control.slow_core_enable = 1'b0;
        end

        // Gating follows the written words at the end of the current CPU cycle
        if (cpu_clk_en) begin
            state_d.live = state_d.sw;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    doze_divider u_divider (
        .pclk             (pclk),
        .presetn          (presetn),
        .slow_core_enable (state_q.clock_divider_control.slow_core_enable),
        .doze_ratio       (state_q.clock_divider_control.doze_ratio),
        .cpu_clk_en       (cpu_clk_en),
        .ratio_act        (ratio_act)
    );

    assign prdata        = state_q.rdata;
    assign pready        = 1'b1;
    assign pslverr       = psel && penable && state_q.rerr;
    // Peripherals never see doze; the system clock keeps its source and speed
    assign periph_clk_en = 1'b1;
    assign doze_active   = (ratio_act != clk_gate_pkg::RATIO_1TO1);
    assign module_off    = state_q.live;
    // A cleared enable stops the module's clock and blocks its register strobes
    assign module_clk_en = ~state_q.live;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence clock_divider_control_write_s;
        psel && penable && pwrite && pready && sel == clk_gate_pkg::SEL_CLOCK_DIVIDER_CONTROL;
    endsequence

    sequence roi_irq_s;
        irq_pending && state_q.clock_divider_control.recover_on_interrupt;
    endsequence

    periph_full_a: assert property (periph_clk_en && (cpu_clk_en -> periph_clk_en))
        else $error("Peripheral clock enable dropped");
    lock_step_a: assert property (!state_q.clock_divider_control.slow_core_enable
        && ratio_act == 3'h0 |=> ratio_act == 3'h0 && cpu_clk_en)
        else $error("CPU enable lost step with peripherals at 1:1");
    ratio_write_a: assert property (!$past(wr_access) |->
        $stable(state_q.clock_divider_control.doze_ratio))
        else $error("Ratio field changed without a write");
    roi_exit_a: assert property (roi_irq_s |=>
        !state_q.clock_divider_control.slow_core_enable ##[0:128] ratio_act == 3'h0)
        else $error("Interrupt did not restore full speed");
    no_roi_hold_a: assert property (irq_pending &&
        !state_q.clock_divider_control.recover_on_interrupt && !wr_access
        |=> $stable(state_q.clock_divider_control))
        else $error("Interrupt changed doze without recovery enabled");
    ctl_write_a: assert property (clock_divider_control_write_s ##0
        !(irq_pending && state_q.clock_divider_control.recover_on_interrupt) |=>
        state_q.clock_divider_control.slow_core_enable == $past(pstrb[1] ? pwdata[11]
        : state_q.clock_divider_control.slow_core_enable))
        else $error("Slow core enable not taken from write data");
    word6_zero_a: assert property ((state_q.sw.module_disable_word6
        & ~clk_gate_pkg::MASK_W6) == 16'h0000)
        else $error("Unimplemented word6 bits set");
    word3_zero_a: assert property (state_q.sw.module_disable_word3[11] == 1'b0)
        else $error("Unimplemented word3 bit set");
    gate_delay_a: assert property (cpu_clk_en |=> module_off == $past(state_d.sw))
        else $error("Disable word not applied at CPU boundary");
    gate_hold_a: assert property (!cpu_clk_en |=> $stable(module_off))
        else $error("Gating changed inside a CPU cycle");
    clk_en_inv_a: assert property (module_clk_en == ~module_off)
        else $error("Module clock enable not inverse of disable");
    word1_write_a: assert property (psel && penable && pwrite && sel == clk_gate_pkg::SEL_W1
        && pstrb[1:0] == 2'h3 |=> state_q.sw.module_disable_word1 == $past(pwdata[15:0]))
        else $error("Word1 write lost");
    word2_write_a: assert property (psel && penable && pwrite && sel == clk_gate_pkg::SEL_W2
        && pstrb[1:0] == 2'h3 |=> state_q.sw.module_disable_word2 == $past(pwdata[15:0]))
        else $error("Word2 write lost");

endmodule

/* File: verif/core_side_model.sv */
// Far-side stand-in: the CPU core and peripherals that run on the derived enables.
// Assumes one pclk domain; the bench asks for an interrupt through irq_req.
`timescale 1ns/1ns
module core_side_model (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        cpu_clk_en,
    input  wire logic        periph_clk_en,
    input  wire logic        irq_req,
    output logic             irq_pending,
    output logic [15:0]      cpu_ticks,
    output logic [15:0]      periph_ticks
);
    logic [1:0] ack_cnt;

    // The request stays up until the core has run two instructions, as a real handler would
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_pending  <= 1'b0;
            ack_cnt      <= 2'h0;
            cpu_ticks    <= 16'h0000;
            periph_ticks <= 16'h0000;
        end else begin
            if (cpu_clk_en) cpu_ticks <= cpu_ticks + 16'h0001;
            if (periph_clk_en) periph_ticks <= periph_ticks + 16'h0001;
            if (irq_req) begin
                irq_pending <= 1'b1;
                ack_cnt     <= 2'h0;
            end else if (irq_pending && cpu_clk_en) begin
                ack_cnt <= ack_cnt + 2'h1;
                if (ack_cnt == 2'h1) irq_pending <= 1'b0;
            end
        end
    end
endmodule

/* File: verif/doze_gating_ctrl_test.sv */
// Self-checking bench for the doze divider and module disable words.
// Assumes zero or more APB wait states; expectations come from the register map.
`timescale 1ns/1ns
module doze_gating_ctrl_test;
    typedef struct packed {
        logic [15:0] idx;
        logic [15:0] wd;
        logic [15:0] rd;
        logic        err;
        logic [2:0]  slot;
    } row_t;

    logic                       pclk = 1'b0;
    logic                       presetn = 1'b0;
    logic                       psel = 1'b0;
    logic                       penable = 1'b0;
    logic                       pwrite = 1'b0;
    logic [15:0]                paddr = 16'h0000;
    logic [31:0]                pwdata = 32'h0000_0000;
    logic [3:0]                 pstrb = 4'hF;
    logic [31:0]                prdata;
    logic                       pready;
    logic                       pslverr;
    logic                       irq_pending;
    logic                       irq_req = 1'b0;
    logic                       cpu_clk_en;
    logic                       periph_clk_en;
    logic                       doze_active;
    clk_gate_pkg::module_off_t  module_off;
    clk_gate_pkg::module_off_t  module_clk_en;
    logic [95:0]                exp_off;
    logic [31:0]                rd;
    logic                       err;
    int                         fails = 0;
    int                         total_checks = 0;
    int                         n;
    row_t                       rows [7];

    always #10 pclk = ~pclk;

    doze_gating_ctrl uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irq_pending(irq_pending),
        .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en), .doze_active(doze_active),
        .module_off(module_off), .module_clk_en(module_clk_en));

    core_side_model core (.pclk(pclk), .presetn(presetn), .cpu_clk_en(cpu_clk_en),
        .periph_clk_en(periph_clk_en), .irq_req(irq_req), .irq_pending(irq_pending),
        .cpu_ticks(), .periph_ticks());

    task automatic check(input logic [95:0] seen, input logic [95:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic results();
        if (fails == 0 && total_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // One APB transfer; held until pready is seen high at a rising edge
    task automatic apb(input logic wr, input logic [15:0] idx, input logic [31:0] wd,
                       input logic [3:0] strb, output logic [31:0] rdat, output logic serr);
        int k;
        k = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= {idx[13:0], 2'b00};
        pwdata  <= wd;
        pstrb   <= strb;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        rdat = prdata;
        serr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // Cycles from one CPU enable pulse to the next
    task automatic period(output int cnt);
        int k;
        k = 0;
        cnt = 0;
        @(negedge pclk);
        while (cpu_clk_en !== 1'b1 && k < 300) begin
            @(negedge pclk);
            k++;
        end
        do begin
            @(negedge pclk);
            cnt++;
        end while (cpu_clk_en !== 1'b1 && cnt < 300);
    endtask

    task automatic doze(input logic [15:0] ctl, input int exp_per);
        apb(1'b1, clk_gate_pkg::IDX_CLOCK_DIVIDER_CONTROL, {16'h0000, ctl}, 4'hF, rd, err);
        period(n);
        period(n);
        check(n, exp_per);
        check(periph_clk_en, 1'b1);
    endtask

    initial begin
        rows[0] = '{clk_gate_pkg::IDX_W1, 16'hA5A5, 16'hA5A5, 1'b0, 3'h0};
        rows[1] = '{clk_gate_pkg::IDX_W2, 16'h5A5A, 16'h5A5A, 1'b0, 3'h1};
        rows[2] = '{clk_gate_pkg::IDX_W3, 16'hFFFF, 16'hF7FF, 1'b0, 3'h2};
        rows[3] = '{clk_gate_pkg::IDX_W4, 16'hFFFF, 16'h002C, 1'b0, 3'h3};
        rows[4] = '{clk_gate_pkg::IDX_W6, 16'hFFFF, 16'h3F01, 1'b0, 3'h4};
        rows[5] = '{clk_gate_pkg::IDX_W7, 16'hFFFF, 16'h0018, 1'b0, 3'h5};
        rows[6] = '{16'h0761, 16'hFFFF, 16'h0000, 1'b1, 3'h6};
        exp_off = 96'h0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 7; i++) begin
            apb(1'b0, rows[i].idx, 32'h0, 4'hF, rd, err);
            check(rd, 32'h0);
        end
        apb(1'b0, clk_gate_pkg::IDX_CLOCK_DIVIDER_CONTROL, 32'h0, 4'hF, rd, err);
        check(rd, 32'h0);
        period(n);
        check(n, 1);
        foreach (rows[i]) begin
            apb(1'b1, rows[i].idx, {16'h0000, rows[i].wd}, 4'hF, rd, err);
            check(err, rows[i].err);
            apb(1'b0, rows[i].idx, 32'h0, 4'hF, rd, err);
            check(rd, {16'h0000, rows[i].rd});
            if (rows[i].slot < 3'h6) exp_off[95 - 16 * rows[i].slot -: 16] = rows[i].rd;
            repeat (2) @(negedge pclk);
            check(module_off, exp_off);
            check(module_clk_en, ~exp_off);
        end
        for (int i = 0; i < 6; i++) apb(1'b1, rows[i].idx, 32'h0, 4'hF, rd, err);
        apb(1'b1, clk_gate_pkg::IDX_W1, 32'hFFFF, 4'h2, rd, err);
        apb(1'b0, clk_gate_pkg::IDX_W1, 32'h0, 4'hF, rd, err);
        check(rd, 32'hFF00);
        repeat (2) @(negedge pclk);
        check(module_off, {16'hFF00, 80'h0});
        // Every ratio code, then a ratio with doze left off
        for (int r = 0; r < 8; r++) doze({1'b0, r[2:0], 1'b1, 11'h000}, 1 << r);
        check(doze_active, 1'b1);
        doze(16'h7000, 1);
        check(doze_active, 1'b0);
        // Disable change in doze waits for the next CPU boundary
        doze(16'h3800, 8);
        apb(1'b1, clk_gate_pkg::IDX_W2, 32'h0001, 4'hF, rd, err);
        @(negedge pclk);
        check(module_off, {16'hFF00, 80'h0});
        repeat (9) @(negedge pclk);
        check(module_off, {16'hFF00, 16'h0001, 64'h0});
        // Interrupt with and without recovery enabled
        doze(16'h2800, 4);
        @(posedge pclk);
        irq_req <= 1'b1;
        @(posedge pclk);
        irq_req <= 1'b0;
        repeat (200) @(posedge pclk);
        apb(1'b0, clk_gate_pkg::IDX_CLOCK_DIVIDER_CONTROL, 32'h0, 4'hF, rd, err);
        check(rd, 32'h2800);
        period(n);
        check(n, 4);
        doze(16'hA800, 4);
        @(posedge pclk);
        irq_req <= 1'b1;
        @(posedge pclk);
        irq_req <= 1'b0;
        repeat (200) @(posedge pclk);
        apb(1'b0, clk_gate_pkg::IDX_CLOCK_DIVIDER_CONTROL, 32'h0, 4'hF, rd, err);
        check(rd, 32'hA000);
        period(n);
        check(n, 1);
        // Reset again in mid-run while in doze with modules off
        doze(16'h2800, 4);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, clk_gate_pkg::IDX_CLOCK_DIVIDER_CONTROL, 32'h0, 4'hF, rd, err);
        check(rd, 32'h0);
        check(module_off, 96'h0);
        period(n);
        check(n, 1);
        results();
    end

    // Whole run is under two thousand cycles; this margin only trips on a hang
    initial begin
        #400000;
        fails++;
        results();
    end
endmodule
